// ### hdl/otpbk_consts.svh
/*
 Constants for the bootstrap configuration bank: register offsets, field positions,
 reset values and decode figures. Assumes inclusion once per compilation unit.
*/
`ifndef OTPBK_CONSTS_SVH
`define OTPBK_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OTPBK_ADDR_SERIAL_ONE 16'h7806
`define OTPBK_ADDR_SERIAL_ZERO 16'h7807
`define OTPBK_ADDR_CUST_TAG 16'h7810
`define OTPBK_ADDR_BUCK12 16'h7811
`define OTPBK_ADDR_STATUS 16'h7820

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define OTPBK_BURN_BIT 15
`define OTPBK_TAG_HI 14
`define OTPBK_TAG_LO 1
`define OTPBK_LOCK_BIT 0
`define OTPBK_B2_SLOT_HI 15
`define OTPBK_B2_SLOT_LO 13
`define OTPBK_B2_VSEL_HI 12
`define OTPBK_B2_VSEL_LO 8
`define OTPBK_B1_SLOT_HI 7
`define OTPBK_B1_SLOT_LO 5
`define OTPBK_B1_VSEL_HI 4
`define OTPBK_B1_VSEL_LO 0
`define OTPBK_RESET_WORD 16'h0000

// ----------------------------------------------------------------------------
// voltage code limits
// ----------------------------------------------------------------------------
`define OTPBK_CODE_MIN 7'h08
`define OTPBK_CODE_MAX 7'h68
`define OTPBK_CODE_FAST_MAX 7'h48

`endif

// ### hdl/otpbk_pkg.sv
/*
 Types for the bootstrap configuration bank.
 Assumes the constants header is compiled alongside.
*/
package otpbk_pkg;

    // start source decoded from a 3-bit slot field
    typedef enum logic [1:0] {
        OTPBK_SRC_NEVER = 2'b00,
        OTPBK_SRC_SLOT = 2'b01,
        OTPBK_SRC_HW1 = 2'b10,
        OTPBK_SRC_HW2 = 2'b11
    } otpbk_src_type;

    // burn sequencer states
    typedef enum logic [1:0] {
        OTPBK_ST_IDLE = 2'b00,
        OTPBK_ST_BURN = 2'b01,
        OTPBK_ST_DONE = 2'b10
    } otpbk_state_type;

endpackage : otpbk_pkg

// ### hdl/otpbk_bank.sv
/*
 Bootstrap configuration bank: serial words, customer tag with burn-on-load and
 final-lock, and buck 1/2 start-up fields with decoded start source and voltage code.
 Assumes a single 10 MHz clock, synchronous reset, and a register port with read data
 one cycle after the read strobe. Load, ON-request and fast-mode inputs are same-domain.
*/
// Implementation choice: the address-and-strobe port.
// Functional notes
// - burn loaded emulation content when burn-on-load set in a dev-mode load
// - ON request checks non-zero customer tag bits 14:1
// - lock in array and copy rejects writes
// - decode buck2 slot: never, slots, hw1, hw2
// - decode buck1 slot with same encoding
// - buck2 code clamps below 08h, above 68h
// - buck2 stored field gives upper five bits
// - buck1 code clamps, 08h lowest step
// - buck1 stored field gives upper five bits
// - fast switching caps code at 48h
`include "otpbk_consts.svh"

module otpbk_bank
    import otpbk_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // bootstrap load
    input wire logic load_in,
    input wire logic load_dev_mode_in,
    input wire logic [15:0] load_serial_one_in,
    input wire logic [15:0] load_serial_zero_in,
    input wire logic [15:0] load_tag_in,
    input wire logic [15:0] load_buck_in,
    input wire logic array_lock_in,
    // otp programming
    output logic prog_req_out,
    output logic [15:0] prog_addr_out,
    output logic [15:0] prog_data_out,
    input wire logic prog_ack_in,
    // power-up control
    input wire logic on_req_in,
    input wire logic buck1_fast_in,
    input wire logic buck2_fast_in,
    output logic on_grant_out,
    output logic on_reject_out,
    output logic [1:0] buck1_src_out,
    output logic [2:0] buck1_slot_out,
    output logic [6:0] buck1_code_out,
    output logic [1:0] buck2_src_out,
    output logic [2:0] buck2_slot_out,
    output logic [6:0] buck2_code_out
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ser1;
        logic [15:0] ser0;
        logic [15:0] tag;
        logic [15:0] buck;
        logic lock_arr;
        logic wr_rejected;
        otpbk_state_type st;
        logic [1:0] burn_idx;
        logic [15:0] rdata;
        logic prog_req;
        logic [15:0] prog_addr;
        logic [15:0] prog_data;
        logic grant;
        logic reject;
        logic [1:0] b1_src;
        logic [2:0] b1_slot;
        logic [6:0] b1_code;
        logic [1:0] b2_src;
        logic [2:0] b2_slot;
        logic [6:0] b2_code;
    } otpbk_regs_type;

    otpbk_regs_type s_r;
    otpbk_regs_type s_nxt;

    // slot field to start source; slot number is only meaningful for SRC_SLOT
    function automatic otpbk_src_type slot_src(input logic [2:0] f);
        otpbk_src_type r;
        case (f)
            3'h0: r = OTPBK_SRC_NEVER;
            3'h6: r = OTPBK_SRC_HW1;
            3'h7: r = OTPBK_SRC_HW2;
            default: r = OTPBK_SRC_SLOT;
        endcase
        return r;
    endfunction : slot_src

    // 5-bit field to 7-bit code, low bits zero, clamped to range and fast limit
    function automatic logic [6:0] volt_code(input logic [4:0] f, input logic fast);
        logic [6:0] c;
        c = {f, 2'b00};
        if (c <= `OTPBK_CODE_MIN) begin
            c = `OTPBK_CODE_MIN;
        end else if (c >= `OTPBK_CODE_MAX) begin
            c = `OTPBK_CODE_MAX;
        end
        if (fast && c > `OTPBK_CODE_FAST_MAX) begin
            c = `OTPBK_CODE_FAST_MAX;
        end
        return c;
    endfunction : volt_code

    // word of the content being burnt, by index
    function automatic logic [15:0] burn_word(input otpbk_regs_type s, input logic [1:0] i);
        logic [15:0] w;
        case (i)
            2'h0: w = s.ser1;
            2'h1: w = s.ser0;
            2'h2: w = s.tag;
            default: w = s.buck;
        endcase
        return w;
    endfunction : burn_word

    function automatic logic [15:0] burn_addr(input logic [1:0] i);
        logic [15:0] a;
        case (i)
            2'h0: a = `OTPBK_ADDR_SERIAL_ONE;
            2'h1: a = `OTPBK_ADDR_SERIAL_ZERO;
            2'h2: a = `OTPBK_ADDR_CUST_TAG;
            default: a = `OTPBK_ADDR_BUCK12;
        endcase
        return a;
    endfunction : burn_addr

    // lock counts only when set both in the array and in the working copy
    logic locked;
    assign locked = s_r.lock_arr && s_r.tag[`OTPBK_LOCK_BIT];

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.grant = 1'b0;
        s_nxt.reject = 1'b0;
        // register writes; serial words are read only
        if (wr_in) begin
            case (addr_in)
                `OTPBK_ADDR_CUST_TAG: s_nxt.tag = wdata_in;
                `OTPBK_ADDR_BUCK12: s_nxt.buck = wdata_in;
                `OTPBK_ADDR_STATUS: s_nxt.wr_rejected = 1'b0;
                default: s_nxt.buck = s_r.buck;
            endcase
        end
        // bootstrap load overrides a same-cycle software write
        if (load_in) begin
            s_nxt.ser1 = load_serial_one_in;
            s_nxt.ser0 = load_serial_zero_in;
            s_nxt.tag = load_tag_in;
            s_nxt.buck = load_buck_in;
            s_nxt.lock_arr = array_lock_in;
        end
        // burn sequencer walks the four words through the programming port
        case (s_r.st)
            OTPBK_ST_IDLE: begin
                if (load_in && load_dev_mode_in && load_tag_in[`OTPBK_BURN_BIT]) begin
                    if (locked) begin
                        s_nxt.wr_rejected = 1'b1;
                    end else begin
                        s_nxt.st = OTPBK_ST_BURN;
                        s_nxt.burn_idx = 2'h0;
                    end
                end
            end
            OTPBK_ST_BURN: begin
                s_nxt.prog_req = 1'b1;
                s_nxt.prog_addr = burn_addr(s_r.burn_idx);
                s_nxt.prog_data = burn_word(s_r, s_r.burn_idx);
                if (s_r.prog_req && prog_ack_in) begin
                    s_nxt.prog_req = 1'b0;
                    if (s_r.burn_idx == 2'h3) begin
                        s_nxt.st = OTPBK_ST_DONE;
                    end else begin
                        s_nxt.burn_idx = s_r.burn_idx + 2'h1;
                    end
                end
            end
            OTPBK_ST_DONE: begin
                s_nxt.prog_req = 1'b0;
                s_nxt.st = OTPBK_ST_IDLE;
            end
            default: s_nxt.st = OTPBK_ST_IDLE;
        endcase
        // ON request: non-zero tag bits 14:1 confirm the data
        if (on_req_in) begin
            if (s_r.tag[`OTPBK_TAG_HI:`OTPBK_TAG_LO] != 14'h0000) begin
                s_nxt.grant = 1'b1;
            end else begin
                s_nxt.reject = 1'b1;
            end
        end
        // start-up decode, continuously from the working copy
        s_nxt.b2_slot = s_r.buck[`OTPBK_B2_SLOT_HI:`OTPBK_B2_SLOT_LO];
        s_nxt.b2_src = slot_src(s_nxt.b2_slot);
        s_nxt.b1_slot = s_r.buck[`OTPBK_B1_SLOT_HI:`OTPBK_B1_SLOT_LO];
        s_nxt.b1_src = slot_src(s_nxt.b1_slot);
        s_nxt.b2_code = volt_code(s_r.buck[`OTPBK_B2_VSEL_HI:`OTPBK_B2_VSEL_LO],
            buck2_fast_in);
        s_nxt.b1_code = volt_code(s_r.buck[`OTPBK_B1_VSEL_HI:`OTPBK_B1_VSEL_LO],
            buck1_fast_in);
        // read data stands only in the cycle after the strobe
        s_nxt.rdata = 16'h0000;
        if (rd_in) begin
            case (addr_in)
                `OTPBK_ADDR_SERIAL_ONE: s_nxt.rdata = s_r.ser1;
                `OTPBK_ADDR_SERIAL_ZERO: s_nxt.rdata = s_r.ser0;
                `OTPBK_ADDR_CUST_TAG: s_nxt.rdata = s_r.tag;
                `OTPBK_ADDR_BUCK12: s_nxt.rdata = s_r.buck;
                `OTPBK_ADDR_STATUS: s_nxt.rdata = {12'h000, s_r.wr_rejected,
                    s_r.st == OTPBK_ST_BURN, s_r.lock_arr, locked};
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flip-flops
    assign rdata_out = s_r.rdata;
    assign prog_req_out = s_r.prog_req;
    assign prog_addr_out = s_r.prog_addr;
    assign prog_data_out = s_r.prog_data;
    assign on_grant_out = s_r.grant;
    assign on_reject_out = s_r.reject;
    assign buck1_src_out = s_r.b1_src;
    assign buck1_slot_out = s_r.b1_slot;
    assign buck1_code_out = s_r.b1_code;
    assign buck2_src_out = s_r.b2_src;
    assign buck2_slot_out = s_r.b2_slot;
    assign buck2_code_out = s_r.b2_code;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    sequence s_burn_load;
        load_in && load_dev_mode_in && load_tag_in[`OTPBK_BURN_BIT];
    endsequence

    property p_burn_start;
        @(posedge clk_in) disable iff (rst_in)
        (s_burn_load and s_r.st == OTPBK_ST_IDLE && !locked) |=> ##1 prog_req_out;
    endproperty
    a_burn_start: assert property (p_burn_start) else $error("burn not started");

    property p_grant;
        @(posedge clk_in) disable iff (rst_in)
        (on_req_in && s_r.tag[14:1] != 14'h0000) |=> on_grant_out && !on_reject_out;
    endproperty
    a_grant: assert property (p_grant) else $error("valid tag not granted");

    property p_reject;
        @(posedge clk_in) disable iff (rst_in)
        (on_req_in && s_r.tag[14:1] == 14'h0000) |=> on_reject_out && !on_grant_out;
    endproperty
    a_reject: assert property (p_reject) else $error("zero tag not rejected");

    property p_lock;
        @(posedge clk_in) disable iff (rst_in)
        (s_burn_load and locked) |=> ##1 !prog_req_out;
    endproperty
    a_lock: assert property (p_lock) else $error("write to locked array");

    // a refused burn leaves a sticky trace for software
    property p_lock_flag;
        @(posedge clk_in) disable iff (rst_in)
        (s_burn_load and s_r.st == OTPBK_ST_IDLE && locked) |=> s_r.wr_rejected;
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("refused burn not flagged");

    property p_b2_src;
        @(posedge clk_in) disable iff (rst_in)
        $past(s_r.buck[15:13]) == 3'h6 |-> buck2_src_out == OTPBK_SRC_HW1;
    endproperty
    a_b2_src: assert property (p_b2_src) else $error("buck2 slot decode");

    // timeslot codes pass the raw slot number through beside the slot source
    property p_b2_slot;
        @(posedge clk_in) disable iff (rst_in)
        $past(s_r.buck[15:13]) inside {[3'h1:3'h5]} |->
            buck2_src_out == OTPBK_SRC_SLOT && buck2_slot_out == $past(s_r.buck[15:13]);
    endproperty
    a_b2_slot: assert property (p_b2_slot) else $error("buck2 timeslot decode");

    property p_b1_src;
        @(posedge clk_in) disable iff (rst_in)
        $past(s_r.buck[7:5]) == 3'h0 |-> buck1_src_out == OTPBK_SRC_NEVER;
    endproperty
    a_b1_src: assert property (p_b1_src) else $error("buck1 slot decode");

    property p_b1_hw2;
        @(posedge clk_in) disable iff (rst_in)
        $past(s_r.buck[7:5]) == 3'h7 |-> buck1_src_out == OTPBK_SRC_HW2;
    endproperty
    a_b1_hw2: assert property (p_b1_hw2) else $error("buck1 hw enable decode");

    property p_b2_range;
        @(posedge clk_in) disable iff (rst_in)
        !$stable(s_r.buck) |-> ##1 (buck2_code_out >= 7'h08 && buck2_code_out <= 7'h68);
    endproperty
    a_b2_range: assert property (p_b2_range) else $error("buck2 code range");

    // inside both clamps the code is the stored field with two zero bits below it
    property p_b2_low;
        @(posedge clk_in) disable iff (rst_in)
        $past(s_r.buck[12:8]) inside {[5'h03:5'h12]} |->
            buck2_code_out == {$past(s_r.buck[12:8]), 2'b00};
    endproperty
    a_b2_low: assert property (p_b2_low) else $error("buck2 low bits");

    property p_b1_range;
        @(posedge clk_in) disable iff (rst_in)
        ($past(s_r.buck[4:0]) == 5'h1F && !$past(buck1_fast_in)) |-> buck1_code_out == 7'h68;
    endproperty
    a_b1_range: assert property (p_b1_range) else $error("buck1 clamp");

    property p_b1_low;
        @(posedge clk_in) disable iff (rst_in)
        $past(s_r.buck[4:0]) inside {[5'h03:5'h12]} |->
            buck1_code_out == {$past(s_r.buck[4:0]), 2'b00};
    endproperty
    a_b1_low: assert property (p_b1_low) else $error("buck1 low bits");

    property p_fast;
        @(posedge clk_in) disable iff (rst_in)
        $past(buck1_fast_in) && $past(buck2_fast_in) |->
            buck1_code_out <= 7'h48 && buck2_code_out <= 7'h48;
    endproperty
    a_fast: assert property (p_fast) else $error("fast mode code above limit");

endmodule : otpbk_bank

// ### dv/otp_bootstrap_config_bank_test.sv
/*
 Self-checking bench for the bootstrap configuration bank: decode table, reset values,
 register port, ON checks, burn sequence and final lock.
 Assumes the bank's constants header and package are compiled first; one 10 MHz clock.
*/
`include "otpbk_consts.svh"

module otp_bootstrap_config_bank_test
    import otpbk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------------
    // signals and table
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] word;
        logic f1;
        logic f2;
        logic [1:0] s1;
        logic [6:0] c1;
        logic [1:0] s2;
        logic [6:0] c2;
    } otpbk_row_type;

    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic [15:0] addr_in = 16'h0000;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'h0;
    logic rd_in = 1'h0;
    logic [15:0] rdata_out;
    logic load_in = 1'h0;
    logic load_dev_mode_in = 1'h0;
    logic [15:0] ld_w [4] = '{16'h1234, 16'h5678, 16'h8ACE, 16'h23DF};
    logic array_lock_in = 1'h0;
    logic prog_req_out;
    logic [15:0] prog_addr_out;
    logic [15:0] prog_data_out;
    logic prog_ack_in = 1'h0;
    logic on_req_in = 1'h0;
    logic buck1_fast_in = 1'h0;
    logic buck2_fast_in = 1'h0;
    logic on_grant_out;
    logic on_reject_out;
    logic [1:0] buck1_src_out;
    logic [2:0] buck1_slot_out;
    logic [6:0] buck1_code_out;
    logic [1:0] buck2_src_out;
    logic [2:0] buck2_slot_out;
    logic [6:0] buck2_code_out;
    logic [15:0] rv;
    int err_total = 0;
    int checks = 0;
    // slot fields walk 0..7 opposite ways; codes probe both clamps and the fast cap
    otpbk_row_type rows [8] = '{
        '{16'h00E2, 1'h0, 1'h0, 2'h3, 7'h08, 2'h0, 7'h08},
        '{16'h23DF, 1'h0, 1'h0, 2'h2, 7'h68, 2'h1, 7'h0C},
        '{16'h5AB2, 1'h0, 1'h0, 2'h1, 7'h48, 2'h1, 7'h68},
        '{16'h7993, 1'h1, 1'h0, 2'h1, 7'h48, 2'h1, 7'h64},
        '{16'h9F72, 1'h1, 1'h1, 2'h1, 7'h48, 2'h1, 7'h48},
        '{16'hB149, 1'h0, 1'h1, 2'h1, 7'h24, 2'h1, 7'h44},
        '{16'hC13A, 1'h0, 1'h0, 2'h1, 7'h68, 2'h2, 7'h08},
        '{16'hFB03, 1'h0, 1'h0, 2'h0, 7'h0C, 2'h3, 7'h68}
    };

    // clock: 100 ns period
    always #50 clk_in = ~clk_in;

    otpbk_bank i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .load_in(load_in),
        .load_dev_mode_in(load_dev_mode_in), .load_serial_one_in(ld_w[0]),
        .load_serial_zero_in(ld_w[1]), .load_tag_in(ld_w[2]), .load_buck_in(ld_w[3]),
        .array_lock_in(array_lock_in), .prog_req_out(prog_req_out),
        .prog_addr_out(prog_addr_out), .prog_data_out(prog_data_out),
        .prog_ack_in(prog_ack_in), .on_req_in(on_req_in), .buck1_fast_in(buck1_fast_in),
        .buck2_fast_in(buck2_fast_in), .on_grant_out(on_grant_out),
        .on_reject_out(on_reject_out), .buck1_src_out(buck1_src_out),
        .buck1_slot_out(buck1_slot_out), .buck1_code_out(buck1_code_out),
        .buck2_src_out(buck2_src_out), .buck2_slot_out(buck2_slot_out),
        .buck2_code_out(buck2_code_out)
    );

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic give_verdict();
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // sample one nanosecond after the edge so its updates have landed
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask : step

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'h1;
        @(posedge clk_in);
        wr_in <= 1'h0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clk_in);
        rd_in <= 1'h0;
        #1;
        d = rdata_out;
    endtask : rd

    task automatic on_try(input logic g, input logic r);
        @(posedge clk_in);
        on_req_in <= 1'h1;
        @(posedge clk_in);
        on_req_in <= 1'h0;
        #1;
        chk("on_grant", 16'(on_grant_out), 16'(g));
        chk("on_reject", 16'(on_reject_out), 16'(r));
    endtask : on_try

    // the tag word changes on the edge with the rest so the load never races it
    task automatic do_load(input logic dev, input logic lock, input logic [15:0] tag);
        @(posedge clk_in);
        load_dev_mode_in <= dev;
        array_lock_in <= lock;
        ld_w[2] <= tag;
        load_in <= 1'h1;
        @(posedge clk_in);
        load_in <= 1'h0;
    endtask : do_load

    // bounded wait for an offered word; a hang ends the run
    task automatic wait_req(input int lim);
        int n;
        n = 0;
        step();
        while (prog_req_out !== 1'h1 && n < lim) begin
            step();
            n++;
        end
        if (prog_req_out !== 1'h1) begin
            err_total++;
            give_verdict();
        end
    endtask : wait_req

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'h0;
        step();
        step();
        rd(`OTPBK_ADDR_CUST_TAG, rv);
        chk("tag_reset", rv, 16'h0000);
        rd(`OTPBK_ADDR_BUCK12, rv);
        chk("buck_reset", rv, 16'h0000);
        rd(`OTPBK_ADDR_SERIAL_ONE, rv);
        chk("serial_reset", rv, 16'h0000);
        chk("b1_code_reset", 16'(buck1_code_out), 16'h0008);
        chk("b2_code_reset", 16'(buck2_code_out), 16'h0008);
        foreach (rows[i]) begin
            @(posedge clk_in);
            buck1_fast_in <= rows[i].f1;
            buck2_fast_in <= rows[i].f2;
            wr(`OTPBK_ADDR_BUCK12, rows[i].word);
            step();
            step();
            chk("b1_src", 16'(buck1_src_out), 16'(rows[i].s1));
            chk("b1_slot", 16'(buck1_slot_out), 16'(rows[i].word[7:5]));
            chk("b1_code", 16'(buck1_code_out), 16'(rows[i].c1));
            chk("b2_src", 16'(buck2_src_out), 16'(rows[i].s2));
            chk("b2_slot", 16'(buck2_slot_out), 16'(rows[i].word[15:13]));
            chk("b2_code", 16'(buck2_code_out), 16'(rows[i].c2));
            rd(`OTPBK_ADDR_BUCK12, rv);
            chk("buck_rb", rv, rows[i].word);
        end
        // ON checks: only bits 14:1 count, so the outer bits alone still fail
        on_try(1'h0, 1'h1);
        wr(`OTPBK_ADDR_CUST_TAG, 16'h8001);
        on_try(1'h0, 1'h1);
        wr(`OTPBK_ADDR_CUST_TAG, 16'h0002);
        on_try(1'h1, 1'h0);
        rd(16'h7808, rv);
        chk("unmapped", rv, 16'h0000);
        // load without dev mode must not burn, even with the burn bit set
        do_load(1'h0, 1'h0, 16'h8ACE);
        repeat (5) step();
        chk("no_burn", 16'(prog_req_out), 16'h0000);
        // dev-mode load burns the four words in order, one per acknowledge
        do_load(1'h1, 1'h0, 16'h8ACE);
        rd(`OTPBK_ADDR_STATUS, rv);
        chk("burning", rv, 16'h0004);
        for (int w = 0; w < 4; w++) begin
            wait_req(10);
            chk("prog_addr", prog_addr_out, 16'h7806 + 16'((w > 1) ? w + 8 : w));
            chk("prog_data", prog_data_out, ld_w[w]);
            @(posedge clk_in);
            prog_ack_in <= 1'h1;
            @(posedge clk_in);
            prog_ack_in <= 1'h0;
        end
        repeat (3) step();
        chk("burn_end", 16'(prog_req_out), 16'h0000);
        wr(`OTPBK_ADDR_SERIAL_ONE, 16'hFFFF);
        rd(`OTPBK_ADDR_SERIAL_ONE, rv);
        chk("serial_ro", rv, 16'h1234);
        // lock set in array and copy: a later burn load is refused
        do_load(1'h0, 1'h1, 16'h0003);
        do_load(1'h1, 1'h1, 16'h8003);
        repeat (6) step();
        chk("locked_burn", 16'(prog_req_out), 16'h0000);
        rd(`OTPBK_ADDR_STATUS, rv);
        chk("lock_status", rv, 16'h000B);
        wr(`OTPBK_ADDR_STATUS, 16'h0000);
        rd(`OTPBK_ADDR_STATUS, rv);
        chk("reject_clear", rv, 16'h0003);
        // mid-run reset: lock, flags and tag all return to zero
        @(posedge clk_in);
        rst_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'h0;
        step();
        chk("b2_code_rst", 16'(buck2_code_out), 16'h0008);
        rd(`OTPBK_ADDR_STATUS, rv);
        chk("status_rst", rv, 16'h0000);
        on_try(1'h0, 1'h1);
        give_verdict();
    end

endmodule : otp_bootstrap_config_bank_test
